// ---- xfc_consts.vh ----
// constants of the event-driven data transfer controller
// assumes a 24-bit byte address space and 16-bit wide memory data
`ifndef XFC_CONSTS_VH
`define XFC_CONSTS_VH

// register byte offsets on the wishbone slave
`define XFC_OFS_ACT_EN 8'h00
`define XFC_OFS_SOFT_VEC 8'h04
`define XFC_OFS_STATUS 8'h08

// soft vector register layout
`define XFC_SOFT_BIT 7
`define XFC_VEC_W 7

// status register layout
`define XFC_ST_BUSY 0
`define XFC_ST_SOFT_END 1
`define XFC_ST_VEC_LO 8

// first mode word fields
`define XFC_SM_HI 7
`define XFC_SM_LO 6
`define XFC_DM_HI 5
`define XFC_DM_LO 4
`define XFC_MD_HI 3
`define XFC_MD_LO 2
`define XFC_DTS 1
`define XFC_SZ 0

// second mode word fields
`define XFC_CHAIN_ENABLE 7
`define XFC_CHAIN_ON_ZERO_SELECT 6
`define XFC_PER_TRANSFER_IRQ_SELECT 5

// encodings
`define XFC_AM_FIXED 2'h0
`define XFC_AM_INC 2'h2
`define XFC_MD_NORMAL 2'h0
`define XFC_MD_REPEAT 2'h1
`define XFC_MD_BLOCK 2'h2

// descriptor geometry and vector table
`define XFC_DESC_BYTES 24'h00000c
`define XFC_DESC_LAST 3'h5
`define XFC_VEC_TABLE 24'h000400
`define XFC_RAM_PAGE 8'hff
`define XFC_STEP_BYTE 24'h000001
`define XFC_STEP_WORD 24'h000002

// reset values
`define XFC_RST_ACT_EN 1'h0
`define XFC_RST_VEC 7'h00

`endif

// ---- xfc_data_transfer_controller.v ----
// event-driven data transfer controller: descriptor fetch, move, write-back
// assumes a wishbone classic master, a 16-bit memory port acked per access,
// and peripherals that drop their request the cycle after a clear pulse
`timescale 1ns/100ps
`include "xfc_consts.vh"

module xfc_data_transfer_controller #(
    parameter NUM_SRC = 8,
    parameter [6:0] IRQ_VEC_BASE = 7'h40
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire module_stop_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [NUM_SRC-1:0] irq_req_i,
    output reg [NUM_SRC-1:0] flag_clr_o,
    output wire [NUM_SRC-1:0] cpu_irq_o,
    output reg soft_transfer_end_irq_o,
    output reg mem_req_o,
    output reg mem_we_o,
    output reg mem_size_o,
    output reg [23:0] mem_addr_o,
    output reg [15:0] mem_wdata_o,
    input wire [15:0] mem_rdata_i,
    input wire mem_ack_i
);

    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_VEC = 4'h1;
    localparam [3:0] S_DRD = 4'h2;
    localparam [3:0] S_RD = 4'h3;
    localparam [3:0] S_WR = 4'h4;
    localparam [3:0] S_DWB = 4'h5;
    localparam [3:0] S_FIN = 4'h6;

    reg [3:0] state;
    reg [NUM_SRC-1:0] activation_enable_reg;
    reg soft_activate_bit;
    reg [6:0] soft_vec;
    reg soft_pend;
    reg is_soft;
    reg [NUM_SRC-1:0] cur_onehot;
    reg [6:0] cur_vec;
    reg [23:0] desc_addr;
    reg [2:0] idx;
    reg [7:0] transfer_mode_word_a;
    reg [7:0] transfer_mode_word_b;
    reg [23:0] source_address_info;
    reg [23:0] dest_address_info;
    reg [15:0] transfer_count_a;
    reg [15:0] block_count_b;
    reg hit_zero;

    wire bus_req;
    wire [7:0] bus_ofs;
    wire [1:0] sm;
    wire [1:0] dm;
    wire [1:0] md;
    wire usz;
    wire area_src;
    wire [7:0] block_size_reload;
    wire [7:0] block_size_counter;
    wire [8:0] reload9;
    wire [23:0] step;
    wire [23:0] span;
    wire [23:0] sar_inc;
    wire [23:0] dar_inc;
    wire wrap;
    wire chain_go;
    wire want_irq;
    wire [15:0] rd_unit;

    reg start_hw;
    reg [NUM_SRC-1:0] sel_onehot;
    reg [6:0] sel_vec;
    integer k;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_ofs = {wb_adr_i[7:2], 2'h0};

    // mode word decode
    assign sm = {transfer_mode_word_a[`XFC_SM_HI],
                 transfer_mode_word_a[`XFC_SM_LO]};
    assign dm = {transfer_mode_word_a[`XFC_DM_HI],
                 transfer_mode_word_a[`XFC_DM_LO]};
    assign md = {transfer_mode_word_a[`XFC_MD_HI],
                 transfer_mode_word_a[`XFC_MD_LO]};
    assign usz = transfer_mode_word_a[`XFC_SZ];
    assign area_src = transfer_mode_word_a[`XFC_DTS];
    assign block_size_reload = transfer_count_a[15:8];
    assign block_size_counter = transfer_count_a[7:0];

    // address steps and area span
    assign step = usz ? `XFC_STEP_WORD : `XFC_STEP_BYTE;
    assign reload9 = {(block_size_reload == 8'h00), block_size_reload};
    assign span = usz ? {14'h0000, reload9, 1'b0} : {15'h0000, reload9};
    assign sar_inc = (sm == `XFC_AM_INC) ?
                     source_address_info + step : source_address_info;
    assign dar_inc = (dm == `XFC_AM_INC) ?
                     dest_address_info + step : dest_address_info;
    assign wrap = (md != `XFC_MD_NORMAL) && (block_size_counter == 8'h01);
    assign rd_unit = usz ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]};

    // chaining and end-of-activation decisions
    assign chain_go = transfer_mode_word_b[`XFC_CHAIN_ENABLE] &
                      (~transfer_mode_word_b[`XFC_CHAIN_ON_ZERO_SELECT] | hit_zero);
    assign want_irq = (md == `XFC_MD_REPEAT) ? 1'b0 :
                      (transfer_mode_word_b[`XFC_PER_TRANSFER_IRQ_SELECT] | hit_zero);

    // sources without enable go straight to the cpu
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g = g + 1) begin : g_irq
            assign cpu_irq_o[g] = irq_req_i[g] &
                                  ~activation_enable_reg[g];
        end
    endgenerate

    // lowest pending enabled source wins; a source being cleared waits
    always @* begin
        start_hw = 1'b0;
        sel_onehot = {NUM_SRC{1'b0}};
        sel_vec = `XFC_RST_VEC;
        for (k = NUM_SRC - 1; k >= 0; k = k - 1) begin
            if (irq_req_i[k] & activation_enable_reg[k] &
                ~flag_clr_o[k]) begin
                start_hw = 1'b1;
                sel_onehot = {NUM_SRC{1'b0}};
                sel_onehot[k] = 1'b1;
                sel_vec = IRQ_VEC_BASE + k[6:0];
            end
        end
    end

    // descriptor word k as stored in ram
    function [15:0] desc_word;
        input [2:0] i;
        begin
            case (i)
                3'h0: desc_word = {transfer_mode_word_a,
                                   source_address_info[23:16]};
                3'h1: desc_word = source_address_info[15:0];
                3'h2: desc_word = {transfer_mode_word_b,
                                   dest_address_info[23:16]};
                3'h3: desc_word = dest_address_info[15:0];
                3'h4: desc_word = transfer_count_a;
                default: desc_word = block_count_b;
            endcase
        end
    endfunction

    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            activation_enable_reg <= {NUM_SRC{`XFC_RST_ACT_EN}};
            soft_activate_bit <= 1'b0;
            soft_vec <= `XFC_RST_VEC;
            soft_pend <= 1'b0;
            soft_transfer_end_irq_o <= 1'b0;
            is_soft <= 1'b0;
            cur_onehot <= {NUM_SRC{1'b0}};
            cur_vec <= `XFC_RST_VEC;
            desc_addr <= 24'h000000;
            idx <= 3'h0;
            transfer_mode_word_a <= 8'h00;
            transfer_mode_word_b <= 8'h00;
            source_address_info <= 24'h000000;
            dest_address_info <= 24'h000000;
            transfer_count_a <= 16'h0000;
            block_count_b <= 16'h0000;
            hit_zero <= 1'b0;
            flag_clr_o <= {NUM_SRC{1'b0}};
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_size_o <= 1'b0;
            mem_addr_o <= 24'h000000;
            mem_wdata_o <= 16'h0000;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            // register slave; module stop answers but ignores access
            wb_ack_o <= bus_req;
            flag_clr_o <= {NUM_SRC{1'b0}};
            if (bus_req) begin
                wb_dat_o <= 32'h00000000;
                if (module_stop_i) begin
                    wb_dat_o <= 32'h00000000;
                end else if (wb_we_i & wb_sel_i[0]) begin
                    if (bus_ofs == `XFC_OFS_ACT_EN) begin
                        activation_enable_reg <= wb_dat_i[NUM_SRC-1:0];
                    end else if (bus_ofs == `XFC_OFS_SOFT_VEC) begin
                        if (wb_dat_i[`XFC_SOFT_BIT]) begin
                            if (~soft_activate_bit) begin
                                soft_activate_bit <= 1'b1;
                                soft_vec <= wb_dat_i[6:0];
                                soft_pend <= 1'b1;
                            end
                        end else begin
                            soft_activate_bit <= 1'b0;
                            soft_transfer_end_irq_o <= 1'b0;
                        end
                    end
                end else if (~wb_we_i) begin
                    if (bus_ofs == `XFC_OFS_ACT_EN) begin
                        wb_dat_o[NUM_SRC-1:0] <= activation_enable_reg;
                    end else if (bus_ofs == `XFC_OFS_SOFT_VEC) begin
                        wb_dat_o[7:0] <= {soft_activate_bit, soft_vec};
                    end else if (bus_ofs == `XFC_OFS_STATUS) begin
                        wb_dat_o[`XFC_ST_BUSY] <= (state != S_IDLE);
                        wb_dat_o[`XFC_ST_SOFT_END] <=
                            soft_transfer_end_irq_o;
                        wb_dat_o[`XFC_ST_VEC_LO+6:`XFC_ST_VEC_LO] <=
                            cur_vec;
                    end
                end
            end

            case (state)
                S_IDLE: begin
                    // one activation at a time, soft first
                    if (~module_stop_i & (soft_pend | start_hw)) begin
                        is_soft <= soft_pend;
                        cur_onehot <= soft_pend ? {NUM_SRC{1'b0}} :
                                      sel_onehot;
                        cur_vec <= soft_pend ? soft_vec : sel_vec;
                        soft_pend <= 1'b0;
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b0;
                        mem_size_o <= 1'b1;
                        mem_addr_o <= `XFC_VEC_TABLE +
                            {16'h0000, soft_pend ? soft_vec : sel_vec, 1'b0};
                        state <= S_VEC;
                    end
                end
                S_VEC: begin
                    if (mem_ack_i) begin
                        desc_addr <= {`XFC_RAM_PAGE, mem_rdata_i};
                        mem_addr_o <= {`XFC_RAM_PAGE, mem_rdata_i};
                        idx <= 3'h0;
                        state <= S_DRD;
                    end
                end
                S_DRD: begin
                    if (mem_ack_i) begin
                        case (idx)
                            3'h0: begin
                                transfer_mode_word_a <= mem_rdata_i[15:8];
                                source_address_info[23:16] <=
                                    mem_rdata_i[7:0];
                            end
                            3'h1: source_address_info[15:0] <= mem_rdata_i;
                            3'h2: begin
                                transfer_mode_word_b <= mem_rdata_i[15:8];
                                dest_address_info[23:16] <= mem_rdata_i[7:0];
                            end
                            3'h3: dest_address_info[15:0] <= mem_rdata_i;
                            3'h4: transfer_count_a <= mem_rdata_i;
                            default: block_count_b <= mem_rdata_i;
                        endcase
                        if (idx == `XFC_DESC_LAST) begin
                            // first data read of this descriptor
                            mem_size_o <= transfer_mode_word_a[`XFC_SZ];
                            mem_addr_o <= source_address_info;
                            hit_zero <= 1'b0;
                            state <= S_RD;
                        end else begin
                            mem_addr_o <= mem_addr_o + `XFC_STEP_WORD;
                            idx <= idx + 3'h1;
                        end
                    end
                end
                S_RD: begin
                    if (mem_ack_i) begin
                        source_address_info <= sar_inc;
                        mem_we_o <= 1'b1;
                        mem_addr_o <= dest_address_info;
                        mem_wdata_o <= rd_unit;
                        state <= S_WR;
                    end
                end
                S_WR: begin
                    if (mem_ack_i) begin
                        mem_we_o <= 1'b0;
                        // repeat or block area restores at end of area
                        if (wrap & area_src) begin
                            source_address_info <= source_address_info - span;
                        end
                        if (wrap & ~area_src) begin
                            dest_address_info <= dar_inc - span;
                        end else begin
                            dest_address_info <= dar_inc;
                        end
                        if (md == `XFC_MD_NORMAL) begin
                            // zero load wraps to ffff: 65536 units
                            transfer_count_a <= transfer_count_a - 16'h0001;
                            hit_zero <= (transfer_count_a == 16'h0001);
                        end else if (wrap) begin
                            transfer_count_a[7:0] <= block_size_reload;
                        end else begin
                            transfer_count_a[7:0] <= block_size_counter - 8'h01;
                        end
                        if (md == `XFC_MD_BLOCK & wrap) begin
                            block_count_b <= block_count_b - 16'h0001;
                            hit_zero <= (block_count_b == 16'h0001);
                        end
                        if (md == `XFC_MD_BLOCK & ~wrap) begin
                            mem_addr_o <= source_address_info;
                            state <= S_RD;
                        end else begin
                            mem_req_o <= 1'b0; // descriptor back to ram
                            idx <= 3'h0;
                            mem_we_o <= 1'b1;
                            mem_size_o <= 1'b1;
                            mem_addr_o <= desc_addr;
                            state <= S_DWB;
                        end
                    end
                end
                S_DWB: begin
                    if (~mem_req_o) begin
                        mem_req_o <= 1'b1;
                        mem_wdata_o <= desc_word(3'h0);
                    end else if (mem_ack_i) begin
                        if (idx == `XFC_DESC_LAST) begin
                            mem_we_o <= 1'b0;
                            if (chain_go) begin
                                desc_addr <= desc_addr + `XFC_DESC_BYTES;
                                mem_addr_o <= desc_addr + `XFC_DESC_BYTES;
                                idx <= 3'h0;
                                state <= S_DRD;
                            end else begin
                                mem_req_o <= 1'b0;
                                state <= S_FIN;
                            end
                        end else begin
                            mem_addr_o <= mem_addr_o + `XFC_STEP_WORD;
                            mem_wdata_o <= desc_word(idx + 3'h1);
                            idx <= idx + 3'h1;
                        end
                    end
                end
                S_FIN: begin
                    // only the last link touches flags and enables
                    if (is_soft) begin
                        if (want_irq) begin
                            soft_transfer_end_irq_o <= 1'b1;
                        end else begin
                            soft_activate_bit <= 1'b0;
                        end
                    end else if (want_irq) begin
                        activation_enable_reg <=
                            activation_enable_reg & ~cur_onehot;
                    end else begin
                        flag_clr_o <= cur_onehot;
                    end
                    state <= S_IDLE;
                end
                default: begin
                    mem_req_o <= 1'b0;
                    mem_we_o <= 1'b0;
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- xfc_data_transfer_controller_assertions.sv ----
// port assertions for the data transfer controller
// assumes one clock and a synchronous active-high reset; bound below
`timescale 1ns/100ps
module xfc_dtc_checker #(
    parameter NUM_SRC = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire module_stop_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [NUM_SRC-1:0] irq_req_i,
    input wire [NUM_SRC-1:0] flag_clr_o,
    input wire [NUM_SRC-1:0] cpu_irq_o,
    input wire soft_transfer_end_irq_o,
    input wire mem_req_o,
    input wire [23:0] mem_addr_o,
    input wire mem_ack_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire taken = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    property p_ack_next;
        taken |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("register request not acked next cycle");
    property p_ack_pulse;
        wb_ack_o && ce_i |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_stop_zero;
        taken && module_stop_i && !wb_we_i |=> wb_dat_o == 32'h0;
    endproperty
    a_stop_zero: assert property (p_stop_zero)
        else $error("register read in module stop not zero");
    property p_irq_source;
        (cpu_irq_o & ~irq_req_i) == '0;
    endproperty
    a_irq_source: assert property (p_irq_source)
        else $error("cpu irq without its source request");
    property p_clr_pulse;
        |flag_clr_o |=> flag_clr_o == '0;
    endproperty
    a_clr_pulse: assert property (p_clr_pulse)
        else $error("flag clear longer than one cycle");
    property p_clr_no_cpu;
        (flag_clr_o & cpu_irq_o) == '0;
    endproperty
    a_clr_no_cpu: assert property (p_clr_no_cpu)
        else $error("flag cleared while cpu irq passed");
    property p_mem_hold;
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
    endproperty
    a_mem_hold: assert property (p_mem_hold)
        else $error("memory request changed before ack");
    property p_soft_hold;
        soft_transfer_end_irq_o && !(wb_cyc_i && wb_we_i)
            |=> soft_transfer_end_irq_o;
    endproperty
    a_soft_hold: assert property (p_soft_hold)
        else $error("soft end irq dropped without software");
    property p_clr_idle;
        |flag_clr_o |-> !mem_req_o;
    endproperty
    a_clr_idle: assert property (p_clr_idle)
        else $error("flag clear before write-back ended");
endmodule
bind xfc_data_transfer_controller xfc_dtc_checker #(.NUM_SRC(NUM_SRC)) chk (
    .clk_i, .rst_i, .ce_i, .module_stop_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_dat_o, .wb_ack_o, .irq_req_i, .flag_clr_o, .cpu_irq_o,
    .soft_transfer_end_irq_o, .mem_req_o, .mem_addr_o, .mem_ack_i
);

// ---- xfc_mem_model.sv ----
// memory model for the controller's memory port, big-endian words
// assumes a byte store indexed by the low 16 address bits
`timescale 1ns/100ps
module xfc_mem_model (
    input wire clk_i,
    input wire slow_i,
    input wire mem_req_i,
    input wire mem_we_i,
    input wire mem_size_i,
    input wire [23:0] mem_addr_i,
    input wire [15:0] mem_wdata_i,
    output reg [15:0] mem_rdata_o = 16'h0000,
    output reg mem_ack_o = 1'b0
);
    reg [7:0] m [0:65535];
    reg [1:0] dly = 2'h0;
    wire [15:0] a = mem_addr_i[15:0];
    always @(posedge clk_i) begin // ram always answers
        mem_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (mem_req_i && !mem_ack_o) begin
            dly <= dly + 2'h1;
            if (dly >= {slow_i, 1'b0}) begin
                dly <= 2'h0;
                mem_ack_o <= 1'b1;
                mem_rdata_o <= mem_size_i ? {m[a], m[a + 16'h1]}
                    : {~m[a], m[a]};
                if (mem_we_i && mem_size_i) begin
                    m[a] <= mem_wdata_i[15:8];
                    m[a + 16'h1] <= mem_wdata_i[7:0];
                end else if (mem_we_i)
                    m[a] <= mem_wdata_i[7:0];
            end
        end
    end
endmodule

// ---- xfc_data_transfer_controller_test.sv ----
// self-checking bench for the data transfer controller
// assumes the memory model and the checker bind are compiled first
`timescale 1ns/100ps
module xfc_data_transfer_controller_test;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg module_stop_i = 1'b0;
    reg ce_i = 1'b1;
    reg wb_cyc_i = 1'b0;
    reg wb_stb_i = 1'b0;
    reg wb_we_i = 1'b0;
    reg [7:0] wb_adr_i = 8'h00;
    reg [3:0] wb_sel_i = 4'h0;
    reg [31:0] wb_dat_i = 32'h0;
    reg [7:0] irq_req_i = 8'h00;
    reg slow = 1'b0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, soft_transfer_end_irq_o, mem_req_o, mem_we_o;
    wire mem_size_o, mem_ack_i;
    wire [7:0] flag_clr_o, cpu_irq_o;
    wire [23:0] mem_addr_o;
    wire [15:0] mem_wdata_o, mem_rdata_i;
    integer errors = 0, tests_run = 0, seed = 47888;
    integer cycles = 0, clr_cnt = 0, k, j;
    reg [31:0] rd_q[$];
    reg [15:0] r [0:3];
    xfc_data_transfer_controller #(.NUM_SRC(8)) uut (
        .clk_i, .rst_i, .ce_i, .module_stop_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .irq_req_i, .flag_clr_o, .cpu_irq_o, .soft_transfer_end_irq_o,
        .mem_req_o, .mem_we_o, .mem_size_o, .mem_addr_o, .mem_wdata_o,
        .mem_rdata_i, .mem_ack_i
    );
    xfc_mem_model mdl (
        .clk_i, .slow_i(slow), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
        .mem_size_i(mem_size_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
        .mem_ack_o(mem_ack_i)
    );
    initial forever #2.5 clk_i = ~clk_i;
    task stop_test;
        if (errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task check(input [31:0] seen, input [31:0] exp, input string what);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wb(input we, input [7:0] adr, input [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task rd(input [7:0] adr, input [31:0] exp);
        rd_q.push_back(exp);
        wb(1'b0, adr, 32'h0);
    endtask
    task put(input [15:0] a, input [15:0] v);
        mdl.m[a] = v[15:8];
        mdl.m[a + 16'h1] = v[7:0];
    endtask
    function [15:0] get(input [15:0] a);
        get = {mdl.m[a], mdl.m[a + 16'h1]};
    endfunction
    task desc(input [15:0] b, input [7:0] ma, input [15:0] s,
              input [7:0] mb, input [15:0] d, input [15:0] ca, cb);
        put(b, {ma, 8'h00});
        put(b + 16'h2, s);
        put(b + 16'h4, {mb, 8'h00});
        put(b + 16'h6, d);
        put(b + 16'h8, ca);
        put(b + 16'ha, cb);
    endtask
    task wait_done;
        k = 0;
        while (k < 8) begin
            @(posedge clk_i);
            k = (mem_req_o === 1'b1) ? 0 : k + 1;
        end
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (wb_ack_o === 1'b1 && !wb_we_i && rd_q.size() > 0)
            check(wb_dat_o, rd_q.pop_front(), "register");
        if (|flag_clr_o) begin
            irq_req_i <= irq_req_i & ~flag_clr_o;
            clr_cnt <= clr_cnt + 1;
        end
        if (cycles == 20000) begin
            errors = errors + 1;
            stop_test;
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h00, 0);
        rd(8'h08, 0);
        rd(8'h0c, 0);
        for (j = 0; j < 4; j = j + 1)
            r[j] = $random(seed);
        put(16'h4000, r[0]);
        put(16'h4002, r[1]);
        put(16'h5000, r[2]);
        put(16'h5002, r[3]);
        put(16'h5200, r[0]);
        put(16'h0480, 16'h1000);
        put(16'h0482, 16'h1100);
        put(16'h04c0, 16'h1200);
        put(16'h04c2, 16'h1300);
        desc(16'h1000, 8'h20, 16'h3000, 8'h00, 16'h3100, 2, 0);
        desc(16'h1100, 8'h00, 16'h3000, 8'h20, 16'h3200, 0, 0);
        desc(16'h1200, 8'ha8, 16'h4000, 8'h00, 16'h4100, 16'h0404, 1);
        desc(16'h1300, 8'h87, 16'h5000, 8'h80, 16'h5100, 16'h0202, 0);
        desc(16'h130c, 8'h01, 16'h5200, 8'h00, 16'h5300, 5, 0);
        wb(1'b1, 8'h00, 32'h3);
        rd(8'h00, 3);
        for (j = 0; j < 2; j = j + 1) begin
            mdl.m[16'h3000] = r[j][7:0];
            irq_req_i <= 8'h01;
            wait_done;
            check(mdl.m[16'h3100 + j], r[j][7:0], "byte");
            check(get(16'h1006), 16'h3101 + j, "dest");
            check(get(16'h1008), 1 - j, "count");
            check(clr_cnt, 1, "clears");
            check(cpu_irq_o, j, "cpu irq");
        end
        check(get(16'h1002), 16'h3000, "fixed src");
        rd(8'h00, 2);
        irq_req_i <= 8'h02;
        wait_done;
        check(get(16'h1108), 16'hffff, "zero count");
        check(clr_cnt, 1, "clears");
        check(cpu_irq_o, 8'h02, "per_transfer_irq_select irq");
        wb(1'b1, 8'h04, 32'he0);
        rd(8'h04, 32'he0);
        wb(1'b1, 8'h04, 32'hc1);
        rd(8'h04, 32'he0);
        rd(8'h08, 32'h6001);
        wait_done;
        rd(8'h08, 32'h6002);
        check(get(16'h4100), r[0], "block");
        check(get(16'h4102), r[1], "block");
        check(get(16'h120a), 0, "blocks");
        check(get(16'h1208), 16'h0404, "size");
        check(get(16'h1202), 16'h4004, "src");
        check(get(16'h1206), 16'h4100, "area");
        check(soft_transfer_end_irq_o, 1, "soft end");
        wb(1'b1, 8'h04, 32'h00);
        check(soft_transfer_end_irq_o, 0, "soft end");
        slow <= 1'b1;
        for (j = 0; j < 2; j = j + 1) begin
            wb(1'b1, 8'h04, 32'he1);
            ce_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            ce_i <= 1'b1;
            wait_done;
            check(get(16'h5100), r[2 + j], "repeat");
            check(soft_transfer_end_irq_o, 0, "soft end");
            rd(8'h04, 32'h61);
        end
        check(get(16'h1302), 16'h5000, "reload");
        check(get(16'h1308), 16'h0202, "reload");
        check(get(16'h1314), 3, "link two");
        check(get(16'h5300), r[0], "link two");
        wb(1'b1, 8'h00, 32'h4);
        module_stop_i <= 1'b1;
        wb(1'b1, 8'h00, 32'h1);
        rd(8'h00, 0);
        module_stop_i <= 1'b0;
        rd(8'h00, 4);
        repeat (2) @(posedge clk_i);
        stop_test;
    end
endmodule
